// ---- media_side_if.sv ----
module media_side_if #(
    parameter int unsigned LINK_KHZ = 250000
) (
    // System clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Strap levels
    input  wire logic [1:0]              mode_pin,
    input  wire logic [1:0]              speed_pin,
    // Received bytes from the line decoder
    input  wire logic [7:0]              line_rx_data,
    input  wire logic                    line_rx_valid,
    input  wire logic                    line_rx_err,
    output logic                         line_rx_ready,
    // Link clock
    input  wire logic                    link_clk,
    // MAC transmit side
    input  wire logic [7:0]              tx_d,
    input  wire logic                    tx_en_ctl,
    input  wire logic                    tx_er,
    output logic                         tx_clk,
    // MAC receive side
    output logic                         rx_clk,
    output logic [7:0]                   rx_d,
    output logic                         rx_dv_ctl,
    output logic                         rx_er,
    // Transmit symbols to the line coder
    output logic [7:0]                   line_tx_data,
    output media_if_pkg::sym_kind_t      line_tx_kind,
    output logic                         line_tx_stb
);
    localparam logic [7:0] HALF_10   = 8'(LINK_KHZ / (2 * media_if_pkg::RX_KHZ_10));
    localparam logic [7:0] HALF_100  = 8'(LINK_KHZ / (2 * media_if_pkg::RX_KHZ_100));
    localparam logic [7:0] HALF_1000 = 8'(LINK_KHZ / (2 * media_if_pkg::RX_KHZ_1000));

    // Divider must reach 125 MHz and still fit 2.5 MHz in eight bits
    if (LINK_KHZ < 2 * media_if_pkg::RX_KHZ_1000 || LINK_KHZ / (2 * media_if_pkg::RX_KHZ_10) > 255)
    begin : g_bad_rate
        $error("LINK_KHZ cannot produce the receive clock rates");
    end

    // ----------------------------------------
    // Link reset and strap synchronisers
    // ----------------------------------------
    logic       lrst_meta_reg;
    logic       lrst_reg;
    logic [1:0] mode_meta_reg;
    logic [1:0] mode_reg;
    logic [1:0] speed_meta_reg;
    logic [1:0] speed_reg;
    logic [7:0] half_sel;
    logic       div_clk;
    logic       rise_evt;
    logic       fall_evt;

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            lrst_meta_reg <= 1'h1;
            lrst_reg      <= 1'h1;
        end else begin
            lrst_meta_reg <= 1'h0;
            lrst_reg      <= lrst_meta_reg;
        end
    end

    always_ff @(posedge link_clk or posedge lrst_reg) begin
        if (lrst_reg) begin
            mode_meta_reg  <= media_if_pkg::MODE_MII;
            mode_reg       <= media_if_pkg::MODE_MII;
            speed_meta_reg <= media_if_pkg::SPEED_10;
            speed_reg      <= media_if_pkg::SPEED_10;
        end else begin
            mode_meta_reg  <= mode_pin;
            mode_reg       <= mode_meta_reg;
            speed_meta_reg <= speed_pin;
            speed_reg      <= speed_meta_reg;
        end
    end

    // ----------------------------------------
    // Receive and MII transmit clock
    // ----------------------------------------
    // (R4) Speed picks rate
    always_comb begin
        unique case (speed_reg)
            media_if_pkg::SPEED_10:  half_sel = HALF_10;
            media_if_pkg::SPEED_100: half_sel = HALF_100;
            default:                 half_sel = HALF_1000;
        endcase
    end

    rate_clock_div u_div (
        .clk      (link_clk),
        .rst      (lrst_reg),
        .half_cnt (half_sel),
        .clk_out  (div_clk),
        .rise_stb (rise_evt),
        .fall_stb (fall_evt)
    );

    assign rx_clk = div_clk;
    // (R11) MII transmit clock
    assign tx_clk = div_clk;

    // ----------------------------------------
    // Transmit capture
    // ----------------------------------------
    logic [3:0] rise_d_reg;
    logic       rise_ctl_reg;
    logic [3:0] fall_d_reg;
    logic       fall_ctl_reg;
    logic       er_act_reg;

    // (R13) Falling edge half
    always_ff @(negedge link_clk or posedge lrst_reg) begin
        if (lrst_reg) begin
            fall_d_reg   <= 4'h0;
            fall_ctl_reg <= 1'h0;
        end else begin
            fall_d_reg   <= tx_d[3:0];
            fall_ctl_reg <= tx_en_ctl;
        end
    end

    always_ff @(posedge link_clk or posedge lrst_reg) begin
        if (lrst_reg) begin
            rise_d_reg   <= 4'h0;
            rise_ctl_reg <= 1'h0;
        end else begin
            rise_d_reg   <= tx_d[3:0];
            rise_ctl_reg <= tx_en_ctl;
        end
    end

    // MII sampling sits mid-period so it never races the MAC's launch edge
    always_ff @(posedge link_clk or posedge lrst_reg) begin
        if (lrst_reg) begin
            line_tx_stb  <= 1'h0;
            line_tx_data <= media_if_pkg::DATA_RST;
            line_tx_kind <= media_if_pkg::SYM_IDLE;
            er_act_reg   <= 1'h0;
        end else begin
            line_tx_stb <= 1'h0;
            unique case (mode_reg)
                media_if_pkg::MODE_MII: begin
                    if (fall_evt) begin
                        line_tx_stb  <= 1'h1;
                        line_tx_data <= {4'h0, tx_d[3:0]};
                        er_act_reg   <= tx_er;
                        // (R1) Invalid then halt
                        if (tx_er) begin
                            line_tx_kind <= er_act_reg ? media_if_pkg::SYM_HALT
                                                       : media_if_pkg::SYM_INVALID;
                        end else begin
                            line_tx_kind <= tx_en_ctl ? media_if_pkg::SYM_DATA
                                                      : media_if_pkg::SYM_IDLE;
                        end
                    end
                end
                media_if_pkg::MODE_GMII: begin
                    line_tx_stb  <= 1'h1;
                    line_tx_data <= tx_d;
                    er_act_reg   <= 1'h0;
                    // (R2) Error forces invalid
                    if (tx_er) begin
                        line_tx_kind <= media_if_pkg::SYM_INVALID;
                    end else begin
                        line_tx_kind <= tx_en_ctl ? media_if_pkg::SYM_DATA
                                                  : media_if_pkg::SYM_IDLE;
                    end
                end
                media_if_pkg::MODE_RGMII: begin
                    line_tx_stb  <= 1'h1;
                    // (R13) Low then high nibble
                    line_tx_data <= {fall_d_reg, rise_d_reg};
                    er_act_reg   <= 1'h0;
                    // (R8) Decode control line
                    if (rise_ctl_reg ^ fall_ctl_reg) begin
                        line_tx_kind <= media_if_pkg::SYM_INVALID;
                    end else begin
                        line_tx_kind <= rise_ctl_reg ? media_if_pkg::SYM_DATA
                                                     : media_if_pkg::SYM_IDLE;
                    end
                end
                default: begin
                    line_tx_kind <= media_if_pkg::SYM_IDLE;
                    er_act_reg   <= 1'h0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Receive word crossing, system side
    // ----------------------------------------
    // One word in flight; throughput is a few system clocks per byte
    logic [8:0] word_reg;
    logic       req_tgl_reg;
    logic       ack_meta_reg;
    logic       ack_sync_reg;
    logic       ack_tgl_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_meta_reg <= 1'h0;
            ack_sync_reg <= 1'h0;
        end else begin
            ack_meta_reg <= ack_tgl_reg;
            ack_sync_reg <= ack_meta_reg;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            word_reg      <= 9'h000;
            req_tgl_reg   <= 1'h0;
            line_rx_ready <= 1'h1;
        end else if (line_rx_ready && line_rx_valid) begin
            word_reg      <= {line_rx_err, line_rx_data};
            req_tgl_reg   <= ~req_tgl_reg;
            line_rx_ready <= 1'h0;
        end else if (!line_rx_ready && ack_sync_reg == req_tgl_reg) begin
            line_rx_ready <= 1'h1;
        end
    end

    // ----------------------------------------
    // Receive output, link side
    // ----------------------------------------
    logic       req_meta_reg;
    logic       req_sync_reg;
    logic       have_reg;
    logic [8:0] hold_reg;
    logic       nib_reg;
    logic [3:0] hi_reg;
    logic       lo_err_reg;

    always_ff @(posedge link_clk or posedge lrst_reg) begin
        if (lrst_reg) begin
            req_meta_reg <= 1'h0;
            req_sync_reg <= 1'h0;
        end else begin
            req_meta_reg <= req_tgl_reg;
            req_sync_reg <= req_meta_reg;
        end
    end

    always_ff @(posedge link_clk or posedge lrst_reg) begin
        if (lrst_reg) begin
            have_reg    <= 1'h0;
            hold_reg    <= 9'h000;
            ack_tgl_reg <= 1'h0;
            nib_reg     <= 1'h0;
            hi_reg      <= 4'h0;
            lo_err_reg  <= 1'h0;
            rx_d        <= media_if_pkg::DATA_RST;
            rx_dv_ctl   <= 1'h0;
            rx_er       <= 1'h0;
        end else begin
            if (fall_evt) begin
                // (R9) Valid only with data
                rx_dv_ctl <= have_reg;
                rx_er     <= have_reg && hold_reg[8];
                rx_d      <= media_if_pkg::DATA_RST;
                unique case (mode_reg)
                    media_if_pkg::MODE_GMII: begin
                        // (R6) Full byte in GMII
                        rx_d     <= have_reg ? hold_reg[7:0] : media_if_pkg::DATA_RST;
                        have_reg <= 1'h0;
                    end
                    media_if_pkg::MODE_RGMII: begin
                        // (R12) Valid on rising half
                        rx_er      <= 1'h0;
                        rx_d[3:0]  <= have_reg ? hold_reg[3:0] : 4'h0;
                        hi_reg     <= have_reg ? hold_reg[7:4] : 4'h0;
                        lo_err_reg <= have_reg && hold_reg[8];
                        have_reg   <= 1'h0;
                    end
                    default: begin
                        // (R5) Nibbles, low first
                        if (have_reg) begin
                            rx_d[3:0] <= nib_reg ? hold_reg[7:4] : hold_reg[3:0];
                            nib_reg   <= ~nib_reg;
                            have_reg  <= !nib_reg;
                        end
                    end
                endcase
            end else if (rise_evt && mode_reg == media_if_pkg::MODE_RGMII) begin
                // (R12) Valid xor error
                rx_d[3:0] <= hi_reg;
                rx_dv_ctl <= rx_dv_ctl ^ lo_err_reg;
            end
            // Take sits last so a word landing on a receive edge is not cleared
            if (!have_reg && req_sync_reg != ack_tgl_reg) begin
                hold_reg    <= word_reg;
                have_reg    <= 1'h1;
                ack_tgl_reg <= req_sync_reg;
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_mii_invalid_first: assert property ( // R1
        @(posedge link_clk) disable iff (lrst_reg)
        (mode_reg == media_if_pkg::MODE_MII && fall_evt && tx_er && !er_act_reg)
        |=> (line_tx_stb && line_tx_kind == media_if_pkg::SYM_INVALID))
        else $error("MII error did not start with an invalid symbol");

    a_mii_halt_follow: assert property ( // R1
        @(posedge link_clk) disable iff (lrst_reg)
        (mode_reg == media_if_pkg::MODE_MII && fall_evt && tx_er && er_act_reg)
        |=> (line_tx_kind == media_if_pkg::SYM_HALT))
        else $error("MII error did not continue with halt symbols");

    a_gmii_err_code: assert property ( // R2
        @(posedge link_clk) disable iff (lrst_reg)
        (mode_reg == media_if_pkg::MODE_GMII && $stable(mode_reg) && tx_er)
        |=> (line_tx_stb && line_tx_kind == media_if_pkg::SYM_INVALID))
        else $error("GMII error not turned into an invalid code-group");

    a_rx_clk_gig: assert property ( // R4
        @(posedge link_clk) disable iff (lrst_reg)
        (speed_reg == media_if_pkg::SPEED_1000 && $stable(speed_reg) && rise_evt)
        |=> fall_evt ##1 rise_evt)
        else $error("Receive clock not at full gigabit rate");

    a_rx_high_quiet: assert property ( // R6
        @(posedge link_clk) disable iff (lrst_reg)
        (mode_reg != media_if_pkg::MODE_GMII && $stable(mode_reg)) |=> rx_d[7:4] == 4'h0)
        else $error("Upper receive lines driven outside GMII");

    a_rx_dv_stable: assert property ( // R9
        @(posedge link_clk) disable iff (lrst_reg)
        (mode_reg != media_if_pkg::MODE_RGMII && !fall_evt) |=> $stable(rx_dv_ctl) && $stable(rx_d))
        else $error("Receive outputs moved off the receive clock falling edge");

    a_rgmii_tx_decode: assert property ( // R8
        @(posedge link_clk) disable iff (lrst_reg)
        (mode_reg == media_if_pkg::MODE_RGMII && $stable(mode_reg) && rise_ctl_reg && fall_ctl_reg)
        |=> line_tx_kind == media_if_pkg::SYM_DATA && line_tx_data == $past({fall_d_reg, rise_d_reg}))
        else $error("RGMII transmit byte decoded wrongly");

    a_rx_word_held: assert property ( // R5
        @(posedge clk) disable iff (rst)
        (line_rx_ready && line_rx_valid) |=> !line_rx_ready [*2])
        else $error("Receive crossing took a second word too early");

endmodule : media_side_if

// ---- media_if_pkg.sv ----
// What this block does
// (R1) MII transmit error: first nibble invalid, then halt symbols until error drops.
// (R2) GMII transmit error puts invalid code-groups into the outgoing frame.
// (R3) MAC supplies a free-running 125 MHz transmit clock in GMII and RGMII; this block takes no such clock and samples transmit data on link_clk.
// (R4) Receive clock is 2.5, 25 or 125 MHz by link speed.
// (R5) Low four receive data lines driven in all modes, changing with receive clock.
// (R6) High four receive data lines used only in GMII, full byte per clock.
// (R7) MAC raises transmit enable whenever transmit data is valid.
// (R8) RGMII transmit control carries enable and error across both clock edges.
// (R9) Receive data valid high exactly while receive data lines hold valid data.
// (R10) MAC drives transmit data on its own clock, or ours in MII.
// (R11) In MII the device drives a 2.5 or 25 MHz transmit clock.
// (R12) RGMII receive control carries valid and error across both clock edges.
// (R13) RGMII moves low nibble on rising, high nibble on falling edge.
package media_if_pkg;

    // ----------------------------------------
    // Interface modes and speeds
    // ----------------------------------------
    localparam logic [1:0] MODE_MII   = 2'h0;
    localparam logic [1:0] MODE_GMII  = 2'h1;
    localparam logic [1:0] MODE_RGMII = 2'h2;

    localparam logic [1:0] SPEED_10   = 2'h0;
    localparam logic [1:0] SPEED_100  = 2'h1;
    localparam logic [1:0] SPEED_1000 = 2'h2;

    // ----------------------------------------
    // Receive clock rates in kHz
    // ----------------------------------------
    localparam int unsigned RX_KHZ_10   = 2500;
    localparam int unsigned RX_KHZ_100  = 25000;
    localparam int unsigned RX_KHZ_1000 = 125000;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] CNT_RST  = 8'h00;

    // ----------------------------------------
    // Symbol kinds handed to the line coder
    // ----------------------------------------
    typedef enum logic [1:0] {
        SYM_IDLE,
        SYM_DATA,
        SYM_INVALID,
        SYM_HALT
    } sym_kind_t;

endpackage : media_if_pkg

// ----------------------------------------
// Receive and transmit clock divider
// ----------------------------------------
module rate_clock_div (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Half period in clk cycles
    input  wire logic [7:0] half_cnt,
    // Divided clock and edge strobes
    output logic            clk_out,
    output logic            rise_stb,
    output logic            fall_stb
);
    logic [7:0] cnt_reg;

    // (R4) Rate by speed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg  <= media_if_pkg::CNT_RST;
            clk_out  <= 1'h0;
            rise_stb <= 1'h0;
            fall_stb <= 1'h0;
        end else if (cnt_reg + 8'h01 >= half_cnt) begin
            cnt_reg  <= media_if_pkg::CNT_RST;
            clk_out  <= ~clk_out;
            rise_stb <= ~clk_out;
            fall_stb <= clk_out;
        end else begin
            cnt_reg  <= cnt_reg + 8'h01;
            rise_stb <= 1'h0;
            fall_stb <= 1'h0;
        end
    end

endmodule : rate_clock_div

// ---- mac_partner.sv ----
module mac_partner (
    // Link clock and strapped mode
    input  wire logic       link_clk,
    input  wire logic [1:0] mode,
    // Receive side from the device
    input  wire logic       rx_clk,
    input  wire logic [7:0] rx_d,
    input  wire logic       rx_dv_ctl,
    input  wire logic       rx_er,
    // Transmit side to the device
    input  wire logic       tx_clk,
    output logic [7:0]      tx_d,
    output logic            tx_en_ctl,
    output logic            tx_er,
    // Bytes seen by the MAC
    output logic [8:0]      got,
    output int              got_cnt,
    output int              bad_hi
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [9:0] txq [$];
    logic [9:0] cur;
    logic [3:0] lo;
    logic       txc_q, rc_q, ctl_r, nib, er_lo;

    initial {tx_d, tx_en_ctl, tx_er, got, got_cnt, bad_hi, cur, txc_q, rc_q, nib} = '0;

    task automatic take(input logic [8:0] b);
        got = b;
        got_cnt = got_cnt + 1;
    endtask : take

    // ----------------------------------------
    // Transmit
    // ----------------------------------------
    // own clock in GMII, device clock in MII, enable beside data
    // RGMII high nibble and en^er on rise, low nibble and enable on fall
    always @(posedge link_clk or negedge link_clk) begin
        if (link_clk) begin
            if (mode == media_if_pkg::MODE_GMII) begin
                cur = (txq.size() > 0) ? txq.pop_front() : 10'h000;
                {tx_en_ctl, tx_er, tx_d} <= cur;
            end else if (mode == media_if_pkg::MODE_RGMII) begin
                tx_d      <= {4'h0, cur[7:4]};
                tx_en_ctl <= cur[9] ^ cur[8];
            end
        end else begin
            // MII data moves on the rising transmit clock, so it stands across the fall
            if (mode == media_if_pkg::MODE_RGMII ||
                (mode == media_if_pkg::MODE_MII && tx_clk && !txc_q)) begin
                cur = (txq.size() > 0) ? txq.pop_front() : 10'h000;
                tx_d      <= {4'h0, cur[3:0]};
                tx_en_ctl <= cur[9];
                tx_er     <= (mode == media_if_pkg::MODE_MII) & cur[8];
            end
            txc_q <= tx_clk;
        end
    end

    // ----------------------------------------
    // Receive
    // ----------------------------------------
    // take what stands half a link cycle after each rising receive clock edge, and after each falling one too in RGMII
    always @(negedge link_clk) begin
        if (mode != media_if_pkg::MODE_GMII && rx_d[7:4] !== 4'h0)
            bad_hi <= bad_hi + 1;
        if (rx_clk && !rc_q) begin
            if (mode == media_if_pkg::MODE_RGMII) begin
                lo    <= rx_d[3:0];
                ctl_r <= rx_dv_ctl;
            end else if (!rx_dv_ctl) begin
                nib <= 1'b0;
            end else if (mode == media_if_pkg::MODE_GMII) begin
                take({rx_er, rx_d});
            end else if (nib) begin
                take({rx_er | er_lo, rx_d[3:0], lo});
                nib <= 1'b0;
            end else begin
                {er_lo, lo} <= {rx_er, rx_d[3:0]};
                nib         <= 1'b1;
            end
        end
        if (!rx_clk && rc_q && mode == media_if_pkg::MODE_RGMII && ctl_r)
            take({ctl_r ^ rx_dv_ctl, rx_d[3:0], lo});
        rc_q <= rx_clk;
    end

endmodule : mac_partner

// ---- test_phy_mac_side_media_interface.sv ----
module test_phy_mac_side_media_interface;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int unsigned LINK_KHZ = 250000;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] speed;
        logic [7:0] data;
        logic       err;
    } row_t;

    localparam row_t ROWS [8] = '{
        '{media_if_pkg::MODE_GMII, media_if_pkg::SPEED_1000, 8'hA5, 1'b0},
        '{media_if_pkg::MODE_GMII, media_if_pkg::SPEED_1000, 8'h3C, 1'b1},
        '{media_if_pkg::MODE_MII, media_if_pkg::SPEED_100, 8'h96, 1'b0},
        '{media_if_pkg::MODE_MII, media_if_pkg::SPEED_10, 8'h0F, 1'b0},
        '{media_if_pkg::MODE_MII, media_if_pkg::SPEED_100, 8'h5A, 1'b1},
        '{media_if_pkg::MODE_RGMII, media_if_pkg::SPEED_1000, 8'hC3, 1'b0},
        '{media_if_pkg::MODE_RGMII, media_if_pkg::SPEED_1000, 8'h7E, 1'b1},
        '{media_if_pkg::MODE_RGMII, media_if_pkg::SPEED_100, 8'h81, 1'b0}
    };
    localparam logic [1:0] CK_MODE [4] = '{2'h0, 2'h0, 2'h1, 2'h2};
    localparam logic [1:0] CK_SPEED [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
    localparam int unsigned CK_KHZ [4] = '{media_if_pkg::RX_KHZ_10, media_if_pkg::RX_KHZ_100,
                                          media_if_pkg::RX_KHZ_1000, media_if_pkg::RX_KHZ_1000};
    localparam logic [1:0] HALT_SEQ [4] = '{2'h2, 2'h3, 2'h3, 2'h1};
    localparam logic [7:0] B2B [3] = '{8'h11, 8'hFE, 8'h80};

    logic                    clk           = 1'b0;
    logic                    link_clk      = 1'b0;
    logic                    rst           = 1'b1;
    logic [1:0]              mode_pin      = 2'h1;
    logic [1:0]              speed_pin     = 2'h2;
    logic [7:0]              line_rx_data  = 8'h00;
    logic                    line_rx_valid = 1'b0;
    logic                    line_rx_err   = 1'b0;
    logic                    line_rx_ready, tx_en_ctl, tx_er, tx_clk, rx_clk, rx_dv_ctl, rx_er;
    logic                    line_tx_stb;
    logic [7:0]              tx_d, rx_d, line_tx_data, msk;
    media_if_pkg::sym_kind_t line_tx_kind;
    logic [8:0]              got;
    logic [8:0]              rxq [$];
    logic [9:0]              txq [$];
    logic [9:0]              v;
    int                      got_cnt, bad_hi, n, cycles = 0, fails = 0, n_checks = 0;

    always #25 clk = ~clk;
    initial begin
        #2.3;
        forever #7.5 link_clk = ~link_clk;
    end

    media_side_if #(.LINK_KHZ(LINK_KHZ)) i_media_side_if (
        .clk(clk), .rst(rst), .mode_pin(mode_pin), .speed_pin(speed_pin),
        .line_rx_data(line_rx_data), .line_rx_valid(line_rx_valid),
        .line_rx_err(line_rx_err), .line_rx_ready(line_rx_ready), .link_clk(link_clk),
        .tx_d(tx_d), .tx_en_ctl(tx_en_ctl), .tx_er(tx_er), .tx_clk(tx_clk),
        .rx_clk(rx_clk), .rx_d(rx_d), .rx_dv_ctl(rx_dv_ctl), .rx_er(rx_er),
        .line_tx_data(line_tx_data), .line_tx_kind(line_tx_kind), .line_tx_stb(line_tx_stb));

    mac_partner i_mac_partner (
        .link_clk(link_clk), .mode(mode_pin), .rx_clk(rx_clk), .rx_d(rx_d),
        .rx_dv_ctl(rx_dv_ctl), .rx_er(rx_er), .tx_clk(tx_clk), .tx_d(tx_d),
        .tx_en_ctl(tx_en_ctl), .tx_er(tx_er), .got(got), .got_cnt(got_cnt), .bad_hi(bad_hi));

    // ----------------------------------------
    // Collectors and tasks
    // ----------------------------------------
    always @(got_cnt) rxq.push_back(got);

    // Idle symbols run every cycle in the fast modes, so only the others are kept
    always @(posedge link_clk)
        if (line_tx_stb === 1'b1 && line_tx_kind !== media_if_pkg::SYM_IDLE)
            txq.push_back({line_tx_kind, line_tx_data});

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] got_v, input logic [31:0] exp_v);
        n_checks++;
        if (got_v !== exp_v) begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask : check

    task automatic do_reset(input logic [1:0] m, input logic [1:0] s);
        rst       <= 1'b1;
        mode_pin  <= m;
        speed_pin <= s;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        rxq.delete();
        txq.delete();
    endtask : do_reset

    // Valid stays up one edge past the take, while ready is low, and must be ignored
    task automatic send_rx(input logic [7:0] d, input logic e);
        @(posedge clk);
        {line_rx_valid, line_rx_err, line_rx_data} <= {1'b1, e, d};
        do @(posedge clk); while (line_rx_ready !== 1'b1);
        @(posedge clk);
        line_rx_valid <= 1'b0;
    endtask : send_rx

    task automatic pull(input bit from_tx, output logic [9:0] q);
        int k;
        k = 0;
        q = 'x;
        while ((from_tx ? txq.size() : rxq.size()) == 0 && k < 3000) begin
            @(posedge clk);
            k++;
        end
        if (from_tx && txq.size() > 0) q = txq.pop_front();
        if (!from_tx && rxq.size() > 0) q = {1'b0, rxq.pop_front()};
    endtask : pull

    task automatic period(input bit of_tx, output int p);
        realtime t0;
        if (of_tx) @(posedge tx_clk); else @(posedge rx_clk);
        t0 = $realtime;
        if (of_tx) @(posedge tx_clk); else @(posedge rx_clk);
        p = int'(($realtime - t0) / 15.0);
    endtask : period

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        check({line_rx_ready, rx_dv_ctl, rx_er, line_tx_stb, rx_d}, 12'h800);
        foreach (ROWS[i]) begin
            do_reset(ROWS[i].mode, ROWS[i].speed);
            send_rx(ROWS[i].data, ROWS[i].err);
            pull(1'b0, v);
            check(v, {1'b0, ROWS[i].err, ROWS[i].data});
            msk = (ROWS[i].mode == media_if_pkg::MODE_MII) ? 8'h0F : 8'hFF;
            i_mac_partner.txq.push_back({1'b1, ROWS[i].err, ROWS[i].data});
            pull(1'b1, v);
            check(v[9:8], ROWS[i].err ? 2'h2 : 2'h1);
            if (!ROWS[i].err) check(v[7:0] & msk, ROWS[i].data & msk);
        end
        // Clock rate per speed; the transmit clock is checked only in MII
        foreach (CK_MODE[s]) begin
            do_reset(CK_MODE[s], CK_SPEED[s]);
            period(1'b0, n);
            check(n, LINK_KHZ / CK_KHZ[s]);
            if (s < 2) begin
                period(1'b1, n);
                check(n, LINK_KHZ / CK_KHZ[s]);
            end
        end
        // Speed code 3 runs at the gigabit rate
        do_reset(2'h3, 2'h3);
        period(1'b0, n);
        check(n, LINK_KHZ / media_if_pkg::RX_KHZ_1000);
        // Error held over three nibbles, then one clean nibble
        do_reset(media_if_pkg::MODE_MII, media_if_pkg::SPEED_100);
        repeat (3) i_mac_partner.txq.push_back(10'h309);
        i_mac_partner.txq.push_back(10'h206);
        foreach (HALT_SEQ[j]) begin
            pull(1'b1, v);
            check(v[9:8], HALT_SEQ[j]);
        end
        check(v[3:0], 4'h6);
        // Back-to-back bytes, none lost and none doubled
        do_reset(media_if_pkg::MODE_GMII, media_if_pkg::SPEED_1000);
        foreach (B2B[j]) send_rx(B2B[j], 1'b0);
        foreach (B2B[j]) begin
            pull(1'b0, v);
            check(v, {2'b00, B2B[j]});
        end
        repeat (50) @(posedge clk);
        check(rxq.size(), 0);
        check(bad_hi, 0);
        give_verdict();
    end

endmodule : test_phy_mac_side_media_interface
